// *** verilog/vse_map.vh ***
// constants for the virtual system-error syndrome and deferral registers
// assumes inclusion by the single design file of this block
`ifndef VSE_MAP_VH
`define VSE_MAP_VH
// coprocessor encodings: opc1, crn, crm, opc2
`define VSE_SYN_OPC1      3'h4
`define VSE_SYN_CRN       4'h5
`define VSE_SYN_CRM       4'h2
`define VSE_SYN_OPC2      3'h3
`define VSE_DEF_OPC1      3'h4
`define VSE_DEF_CRN       4'hc
`define VSE_DEF_CRM       4'h1
`define VSE_DEF_OPC2      3'h1
// field positions
`define VSE_AET_HI        15
`define VSE_AET_LO        14
`define VSE_EXT_BIT       12
`define VSE_PEND_BIT      31
`define VSE_FMT_BIT       9
`define VSE_FS4_BIT       10
// masks of writable bits
`define VSE_SYN_MASK      32'h0000_d000
`define VSE_DEF_MASK_LONG 32'h8000_d23f
`define VSE_DEF_MASK_SHRT 32'h8000_d60f
// fault codes
`define VSE_FS_SHORT      5'h16
`define VSE_FS_LONG       6'h11
// reset values
`define VSE_SYN_RESET     32'h0000_0000
`define VSE_DEF_RESET     32'h0000_0000
// exception levels
`define VSE_EL0           2'h0
`define VSE_EL1           2'h1
`define VSE_EL2           2'h2
`endif

// *** verilog/vse_regs.v ***
// virtual system-error syndrome and deferral status registers, with the
// entry copy into guest fault status and the barrier deferral update.
// assumes the core decodes coprocessor moves and supplies its state as levels
// on the same clock; access strobes are one-cycle pulses.
//
// What this block does
// - on virtual error entry, guest fault status 15:14 gets the syndrome error type
// - on that entry, guest fault status bit 12 gets the syndrome external abort bit
// - syndrome access undefined at EL1/EL0 and in restricted secure or monitor modes
// - both registers exist only with 32-bit EL2 and reliability extension present
// - with 64-bit top level, storage is shared with the 64-bit hypervisor registers
// - one physical copy of each register serves both security states
// - syndrome register is 32-bit read/write at opc1 4, c5, c2, opc2 3
// - deferral register is 32-bit read/write at opc1 4, c12, c1, opc2 1
// - a barrier deferring at non-secure EL1 sets deferral bit 31
// - deferral copies syndrome error type and external abort into 15:14 and 12
// - short format deferral writes fault code 10110 into bit 10 and bits 3:0
// - long format deferral writes fault code 010001 into bits 5:0
// - deferral bit 9 shows format: 1 long, 0 short
// - with routing override set, non-secure EL1 deferred status reaches the virtual copy
// - barrier write is visible to a following deferred status read without sync
// - deferral reserved bits read zero, per format
// - deferral register access undefined under the same level and mode limits
`timescale 1ns/10ps
`include "vse_map.vh"

module vse_regs #(
  parameter HAS_EL2_32   = 1'b1,  // EL2 implemented in the 32-bit state
  parameter HAS_RAS      = 1'b1,  // reliability extension implemented
  parameter HAS_EL3_32   = 1'b1,  // EL3 implemented in the 32-bit state
  parameter TOP_IS_64BIT = 1'b0   // highest level uses the 64-bit state
) (
  input  wire        CLOCK_I,
  input  wire        RST_N_I,
  // coprocessor move request
  input  wire        CP_ACC_I,      // one-cycle access strobe
  input  wire        CP_WRITE_I,    // 1 write, 0 read
  input  wire [2:0]  CP_OPC1_I,
  input  wire [3:0]  CP_CRN_I,
  input  wire [3:0]  CP_CRM_I,
  input  wire [2:0]  CP_OPC2_I,
  input  wire [31:0] CP_WDATA_I,
  // processor state
  input  wire [1:0]  CUR_EL_I,
  input  wire        SECURE_I,
  input  wire        MONITOR_MODE_I,
  input  wire        NONSECURE_STATE_BIT_I,
  input  wire        LONG_FORMAT_I,          // EL1 uses long descriptors
  input  wire        ABORT_ROUTING_OVERRIDE_I,
  input  wire        VIRTUAL_ABORT_PENDING_I,
  // events
  input  wire        VSERR_TAKE_I,           // virtual error taken to EL1, pulse
  input  wire        ERROR_SYNC_BARRIER_I,   // barrier consumed virtual error, pulse
  input  wire        DEF_STATUS_ACC_I,       // deferred status access at EL1, pulse
  input  wire        DEF_STATUS_WRITE_I,
  // 64-bit counterpart write port, shared storage
  input  wire        HYP64_SYN_WE_I,
  input  wire        HYP64_DEF_WE_I,
  input  wire [31:0] HYP64_WDATA_I,
  // answers
  output reg  [31:0] CP_RDATA_O,
  output reg         CP_UNDEF_O,
  output reg         CP_HIT_O,
  output reg  [31:0] DEF_STATUS_RDATA_O,
  output reg         DEF_STATUS_VIRT_O,
  output reg         GUEST_FS_WE_O,
  output reg  [2:0]  GUEST_FS_BITS_O,        // {15:14, 12}
  output wire [31:0] HYP64_SYN_O,
  output wire [31:0] HYP64_DEF_O
);

////////////////////////////////////////////////////////////////////////////////
// decode and permission

  // single storage, shared across security states
  reg  [31:0] syndrome;
  reg  [31:0] deferral;

  wire present = HAS_EL2_32 & HAS_RAS;
  wire sel_syn = (CP_OPC1_I == `VSE_SYN_OPC1) & (CP_CRN_I == `VSE_SYN_CRN) &
                 (CP_CRM_I == `VSE_SYN_CRM) & (CP_OPC2_I == `VSE_SYN_OPC2);
  wire sel_def = (CP_OPC1_I == `VSE_DEF_OPC1) & (CP_CRN_I == `VSE_DEF_CRN) &
                 (CP_CRM_I == `VSE_DEF_CRM) & (CP_OPC2_I == `VSE_DEF_OPC2);

  // both registers carry the same level and mode limits
  wire low_el    = (CUR_EL_I == `VSE_EL0) | (CUR_EL_I == `VSE_EL1);
  wire sec_block = HAS_EL3_32 & ((SECURE_I & ~MONITOR_MODE_I) |
                   (MONITOR_MODE_I & ~NONSECURE_STATE_BIT_I));
  wire denied    = ~present | low_el | sec_block;
  wire hit       = CP_ACC_I & (sel_syn | sel_def);
  wire ok        = hit & ~denied;

  // writable bit mask of the deferral register follows the current format
  wire [31:0] def_mask = LONG_FORMAT_I ? `VSE_DEF_MASK_LONG : `VSE_DEF_MASK_SHRT;

////////////////////////////////////////////////////////////////////////////////
// barrier deferral value

  // short fault code split over bit 10 and bits 3:0, sliced on purpose
  wire [4:0] fs_short = `VSE_FS_SHORT;
  reg [31:0] defer_value;
  always @* begin
    defer_value = 32'h0000_0000;
    defer_value[`VSE_PEND_BIT] = 1'b1;
    defer_value[`VSE_AET_HI:`VSE_AET_LO] = syndrome[`VSE_AET_HI:`VSE_AET_LO];
    defer_value[`VSE_EXT_BIT] = syndrome[`VSE_EXT_BIT];
    defer_value[`VSE_FMT_BIT] = LONG_FORMAT_I;
    if (LONG_FORMAT_I) begin
      defer_value[5:0] = `VSE_FS_LONG;
    end else begin
      defer_value[`VSE_FS4_BIT] = fs_short[4];
      defer_value[3:0] = fs_short[3:0];
    end
  end

  // barrier only defers when running at non-secure EL1
  wire defer_evt = present & ERROR_SYNC_BARRIER_I & (CUR_EL_I == `VSE_EL1) & ~SECURE_I;
  // routed guest access to the deferred status
  wire route = present & ABORT_ROUTING_OVERRIDE_I & DEF_STATUS_ACC_I &
               (CUR_EL_I == `VSE_EL1) & ~SECURE_I;

////////////////////////////////////////////////////////////////////////////////
// storage

  // barrier update wins over a software write in the same cycle, the
  // hardware event must not be lost
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      syndrome <= `VSE_SYN_RESET;
      deferral <= `VSE_DEF_RESET;
    end else begin
      if (ok & sel_syn & CP_WRITE_I)
        syndrome <= CP_WDATA_I & `VSE_SYN_MASK;
      else if (TOP_IS_64BIT & HYP64_SYN_WE_I)
        syndrome <= HYP64_WDATA_I & `VSE_SYN_MASK;
      if (defer_evt)
        deferral <= defer_value;
      else if (ok & sel_def & CP_WRITE_I)
        deferral <= CP_WDATA_I & def_mask;
      else if (route & DEF_STATUS_WRITE_I)
        deferral <= CP_WDATA_I & def_mask;
      else if (TOP_IS_64BIT & HYP64_DEF_WE_I)
        deferral <= HYP64_WDATA_I & def_mask;
    end
  end

  assign HYP64_SYN_O = syndrome;
  assign HYP64_DEF_O = deferral;

////////////////////////////////////////////////////////////////////////////////
// answers, registered one cycle after the request

  // a read in the cycle after a barrier sees the new value since storage
  // updates on the same edge the answer is built from next time
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CP_RDATA_O         <= 32'h0000_0000;
      CP_UNDEF_O         <= 1'b0;
      CP_HIT_O           <= 1'b0;
      DEF_STATUS_RDATA_O <= 32'h0000_0000;
      DEF_STATUS_VIRT_O  <= 1'b0;
      GUEST_FS_WE_O      <= 1'b0;
      GUEST_FS_BITS_O    <= 3'h0;
    end else begin
      CP_HIT_O   <= ok;
      CP_UNDEF_O <= hit & denied;
      if (ok & ~CP_WRITE_I)
        CP_RDATA_O <= sel_syn ? (syndrome & `VSE_SYN_MASK) : (deferral & def_mask);
      else
        CP_RDATA_O <= 32'h0000_0000;
      DEF_STATUS_VIRT_O <= route;
      // forward the barrier value so a following read never sees stale data
      DEF_STATUS_RDATA_O <= defer_evt ? defer_value : (deferral & def_mask);
      // guest fault status copy on virtual error entry
      GUEST_FS_WE_O   <= present & VSERR_TAKE_I & VIRTUAL_ABORT_PENDING_I;
      GUEST_FS_BITS_O <= {syndrome[`VSE_AET_HI:`VSE_AET_LO], syndrome[`VSE_EXT_BIT]};
    end
  end

endmodule // vse_regs

// *** verification/vse_regs_asserts.sv ***
// checker for the syndrome and deferral registers
// assumes a bind onto vse_regs, one clock domain
`timescale 1ns/10ps
module vse_regs_asserts (
  input wire        CLOCK_I,
  input wire        RST_N_I,
  input wire        CP_ACC_I,
  input wire [1:0]  CUR_EL_I,
  input wire        SECURE_I,
  input wire        MONITOR_MODE_I,
  input wire        LONG_FORMAT_I,
  input wire        VIRTUAL_ABORT_PENDING_I,
  input wire        VSERR_TAKE_I,
  input wire        ERROR_SYNC_BARRIER_I,
  input wire        CP_HIT_O,
  input wire        GUEST_FS_WE_O,
  input wire [2:0]  GUEST_FS_BITS_O,
  input wire [31:0] DEF_STATUS_RDATA_O,
  input wire [31:0] HYP64_SYN_O,
  input wire [31:0] HYP64_DEF_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  // only a barrier at non-secure el1 may defer
  wire       error_sync_barrier = ERROR_SYNC_BARRIER_I && CUR_EL_I == 2'h1 && !SECURE_I;
  wire [2:0] syn = {HYP64_SYN_O[15:14], HYP64_SYN_O[12]};
  property p_syn_res; (HYP64_SYN_O & 32'hffff_2fff) == 32'h0000_0000; endproperty
  a_syn_res: assert property (p_syn_res) else $error("syndrome reserved bit set");
  property p_entry; VSERR_TAKE_I && VIRTUAL_ABORT_PENDING_I |=> GUEST_FS_WE_O && GUEST_FS_BITS_O == $past(syn); endproperty
  a_entry: assert property (p_entry) else $error("entry copy wrong");
  property p_flags; error_sync_barrier |=> HYP64_DEF_O[31] && DEF_STATUS_RDATA_O[31] && HYP64_DEF_O[9] == $past(LONG_FORMAT_I); endproperty
  a_flags: assert property (p_flags) else $error("deferral flags wrong");
  property p_code; error_sync_barrier |=> ($past(LONG_FORMAT_I) ? HYP64_DEF_O[5:0] == 6'h11 : {HYP64_DEF_O[10], HYP64_DEF_O[3:0]} == 5'h16); endproperty
  a_code: assert property (p_code) else $error("fault code wrong");
  property p_copy; error_sync_barrier |=> {HYP64_DEF_O[15:14], HYP64_DEF_O[12]} == $past(syn); endproperty
  a_copy: assert property (p_copy) else $error("deferral copy wrong");
  property p_def_res; (HYP64_DEF_O & 32'h7fff_29c0) == 32'h0000_0000; endproperty
  a_def_res: assert property (p_def_res) else $error("deferral reserved bit set");
  property p_low_el; CP_ACC_I && CUR_EL_I < 2'h2 |=> !CP_HIT_O; endproperty
  a_low_el: assert property (p_low_el) else $error("low level access accepted");
  property p_sec; CP_ACC_I && SECURE_I && !MONITOR_MODE_I |=> !CP_HIT_O; endproperty
  a_sec: assert property (p_sec) else $error("secure access accepted");
endmodule // vse_regs_asserts
bind vse_regs vse_regs_asserts chk_u (.*);

// *** verification/tb_top.sv ***
// bench for vse_regs: moves per context, barrier deferral, entry, routing
// assumes the default presence parameters of the design
`timescale 1ns/10ps
module tb_top;
  reg         CLOCK_I = 0, RST_N_I = 0, acc = 0, wr = 0;
  reg  [13:0] enc = 0;
  reg  [7:0]  ctl = 8'h12;
  reg  [2:0]  ev = 0;
  reg  [31:0] wd = 0, syn = 0, r, seed = 42;
  reg  [33:0] e, q[$];
  reg  [35:0] tbl = 36'hf_cf1d_0472; // {ok, ns, mon, sec, el} per context
  wire [31:0] rd;
  wire        hit, und, virt;
  integer     n_mismatch = 0, check_count = 0, i;
  always #5 CLOCK_I = ~CLOCK_I;
  vse_regs dut_u (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .CP_ACC_I(acc), .CP_WRITE_I(wr), .CP_OPC1_I(enc[13:11]),
    .CP_CRN_I(enc[10:7]), .CP_CRM_I(enc[6:3]), .CP_OPC2_I(enc[2:0]), .CP_WDATA_I(wd), .CUR_EL_I(ctl[1:0]),
    .SECURE_I(ctl[2]), .MONITOR_MODE_I(ctl[3]), .NONSECURE_STATE_BIT_I(ctl[4]), .LONG_FORMAT_I(ctl[5]),
    .ABORT_ROUTING_OVERRIDE_I(ctl[6]), .VIRTUAL_ABORT_PENDING_I(ctl[7]), .VSERR_TAKE_I(ev[2]),
    .ERROR_SYNC_BARRIER_I(ev[1]), .DEF_STATUS_ACC_I(ev[0]), .DEF_STATUS_WRITE_I(wr), .HYP64_SYN_WE_I(1'b0),
    .HYP64_DEF_WE_I(1'b0), .HYP64_WDATA_I(32'h0000_0000), .CP_RDATA_O(rd), .CP_UNDEF_O(und), .CP_HIT_O(hit),
    .DEF_STATUS_RDATA_O(), .DEF_STATUS_VIRT_O(virt), .GUEST_FS_WE_O(), .GUEST_FS_BITS_O(), .HYP64_SYN_O(),
    .HYP64_DEF_O());
  task print_verdict;
    begin
      if (q.size() != 0) n_mismatch = n_mismatch + 1;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // one move; an unmatched encoding notes nothing since no answer may come
  task cp(input [13:0] en, input w, input [31:0] d, input [33:0] x);
    begin
      @(posedge CLOCK_I);
      {acc, wr, enc, wd} <= {1'b1, w, en, d};
      if (x[33:32] !== 2'b00) q.push_back(x);
      @(posedge CLOCK_I);
      {acc, wr} <= 2'b00;
    end
  endtask
  task ping(input [2:0] m);
    begin
      @(posedge CLOCK_I);
      ev <= m;
      @(posedge CLOCK_I);
      ev <= 3'h0;
    end
  endtask
  // every answer pulse takes the oldest note
  always @(posedge CLOCK_I) begin
    if (hit === 1'b1 || und === 1'b1) begin
      check_count = check_count + 1;
      e = (q.size() == 0) ? 34'h0 : q.pop_front();
      if ({hit, und, rd} !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t answer %h expected %h", $time, {hit, und, rd}, e);
      end
    end
  end
  initial begin
    repeat (3000) @(posedge CLOCK_I);
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge CLOCK_I);
    RST_N_I <= 1;
    // refused writes must leave the syndrome alone
    for (i = 0; i < 6; i = i + 1) begin
      r = $random(seed);
      ctl[4:0] <= tbl[i*6+:5];
      if (tbl[i*6+5]) cp(14'h2293, 0, 0, {2'b10, syn});
      cp(14'h2293, 1, r, tbl[i*6+5] ? {2'b10, 32'h0} : {2'b01, 32'h0});
      if (tbl[i*6+5]) syn = r & 32'h0000_d000;
      cp(14'h2293, 0, 0, tbl[i*6+5] ? {2'b10, syn} : {2'b01, 32'h0});
    end
    // barrier per format, then software write through the format mask
    for (i = 0; i < 2; i = i + 1) begin
      ctl[5:0] <= {i[0], 5'h11};
      ping(3'b010);
      ctl[1:0] <= 2'h2;
      cp(14'h2609, 0, 0, {2'b10, 32'h8000_0000 | syn | (i ? 32'h0000_0211 : 32'h0000_0406)});
      r = $random(seed);
      cp(14'h2609, 1, r, {2'b10, 32'h0});
      cp(14'h2609, 0, 0, {2'b10, r & (i ? 32'h8000_d23f : 32'h8000_d60f)});
    end
    cp(14'h2290, 0, 0, 34'h0);
    ctl <= 8'hd1;
    ping(3'b101);
    #1;
    check_count = check_count + 1;
    if (virt !== 1'b1) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0t routed access not redirected", $time);
    end
    repeat (3) @(posedge CLOCK_I);
    print_verdict;
  end
endmodule // tb_top
